// ===== rtl/dba_pkg.sv
// shared constants and types of the debug id and permission bank
package dba_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  // register byte offsets
  localparam logic [11:0] PERM_OFS = 12'hfb8;
  localparam logic [11:0] CLASS_OFS = 12'hfcc;
  localparam logic [11:0] ID4_OFS = 12'hfd0;
  localparam logic [11:0] ID5_OFS = 12'hfd4;
  localparam logic [11:0] ID6_OFS = 12'hfd8;
  localparam logic [11:0] ID7_OFS = 12'hfdc;
  localparam logic [11:0] ID0_OFS = 12'hfe0;
  localparam logic [11:0] ID1_OFS = 12'hfe4;
  localparam logic [11:0] ID2_OFS = 12'hfe8;
  localparam logic [11:0] ID3_OFS = 12'hfec;
  // slot codes from address decode
  localparam logic [3:0] SLOT_NONE = 4'h0;
  localparam logic [3:0] SLOT_PERM = 4'h1;
  localparam logic [3:0] SLOT_CLASS = 4'h2;
  localparam logic [3:0] SLOT_ID0 = 4'h3;
  localparam logic [3:0] SLOT_ID1 = 4'h4;
  localparam logic [3:0] SLOT_ID2 = 4'h5;
  localparam logic [3:0] SLOT_ID3 = 4'h6;
  localparam logic [3:0] SLOT_ID4 = 4'h7;
  localparam logic [3:0] SLOT_RSVD = 4'h8;
  // permission status bit positions
  localparam int unsigned PERM_NS_INV_EN = 0;
  localparam int unsigned PERM_NS_INV_IMP = 1;
  localparam int unsigned PERM_NS_NINV_EN = 2;
  localparam int unsigned PERM_NS_NINV_IMP = 3;
  localparam int unsigned PERM_S_INV_EN = 4;
  localparam int unsigned PERM_S_INV_IMP = 5;
  localparam int unsigned PERM_S_NINV_EN = 6;
  localparam int unsigned PERM_S_NINV_IMP = 7;
  // fixed field values
  localparam logic [3:0] CLASS_SUB_TYPE = 4'h1;
  localparam logic [3:0] CLASS_MAIN = 4'h5;
  localparam logic [3:0] BLOCK_COUNT = 4'h0;
  localparam logic ID2_FIXED_ONE = 1'b1;
  // values after reset, synchroniser depth and enable width
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic SYNC_RST = 1'b0;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned EN_W = 4;

  // the four debug enable levels
  typedef struct packed {
    logic inv;
    logic noninv;
    logic sec_inv;
    logic sec_noninv;
  } dba_enables_t;

  // one cycle of the register port
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dba_bus_req_t;

  // read answer phase
  typedef enum logic [1:0] {
    DBA_IDLE = 2'b01,
    DBA_ANSWER = 2'b10
  } dba_state_t;
endpackage : dba_pkg

// ===== rtl/dba_sync.sv
// three stage input synchroniser with agreement filter
`timescale 1ns/100ps
module dba_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] filt_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // widths the chain cannot serve
  if (W < 1) begin : g_chk_w
    $error("W must be at least 1");
  end

  // one chain per bit; output follows once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_r[i] <= dba_pkg::SYNC_RST;
        s2_r[i] <= dba_pkg::SYNC_RST;
        s3_r[i] <= dba_pkg::SYNC_RST;
        filt_out[i] <= dba_pkg::SYNC_RST;
      end else begin
        s1_r[i] <= async_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          filt_out[i] <= s3_r[i];
        end
      end
    end
  end

  // filtered level holds while the late stages disagree
  filt_hold_a: assert property (@(posedge clk) disable iff (rst)
    (s2_r != s3_r) |=> ((filt_out ^ $past(filt_out)) &
      $past(s2_r ^ s3_r)) == '0)
    else $error("filtered input moved while stages disagreed");
endmodule : dba_sync

// ===== rtl/dba_perm.sv
// forms the permission status word from the enable levels
`timescale 1ns/100ps
module dba_perm #(
  parameter bit SEC_EXT = 1'b1
) (
  input dba_pkg::dba_enables_t en,
  output logic [31:0] status
);
  // bit map differs with and without security extensions
  always_comb begin
    status = '0;
    if (SEC_EXT) begin
      status[dba_pkg::PERM_NS_INV_EN] = en.inv;
      status[dba_pkg::PERM_NS_NINV_EN] = en.inv | en.noninv;
      status[dba_pkg::PERM_S_INV_EN] = en.inv & en.sec_inv;
      status[dba_pkg::PERM_S_NINV_EN] = (en.inv | en.noninv) &
        (en.sec_inv | en.sec_noninv);
      status[dba_pkg::PERM_NS_INV_IMP] = 1'b1;
      status[dba_pkg::PERM_NS_NINV_IMP] = 1'b1;
      status[dba_pkg::PERM_S_INV_IMP] = 1'b1;
      status[dba_pkg::PERM_S_NINV_IMP] = 1'b1;
    end else begin
      status[dba_pkg::PERM_S_NINV_IMP] = 1'b1;
      status[dba_pkg::PERM_S_INV_IMP] = 1'b1;
      status[dba_pkg::PERM_S_NINV_EN] = en.inv | en.noninv;
      status[dba_pkg::PERM_S_INV_EN] = en.inv;
      // low nibble stays zero here
    end
  end
endmodule : dba_perm

// ===== rtl/dba_regs.sv
// read-only debug permission and identification register bank
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module dba_regs #(
  parameter int SEC_EXT = 1,
  parameter int PART_NUMBER = 0,
  parameter int DESIGNER_BANK = 0, // arbitrary value
  parameter int DESIGNER_IDENT = 0, // arbitrary value
  parameter int REVISION = 0,
  parameter int FOUNDRY_REVISION = 0,
  parameter int CUSTOMER_MOD = 0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic invasive_debug_enable_in,
  input wire logic noninvasive_debug_enable_in,
  input wire logic secure_invasive_debug_enable_in,
  input wire logic secure_noninvasive_debug_enable_in
);
  // refuse parameter values that do not fit their fields
  if (SEC_EXT < 0 || SEC_EXT > 1) begin : g_chk_sec
    $error("SEC_EXT must be 0 or 1");
  end
  if (PART_NUMBER < 0 || PART_NUMBER > 4095) begin : g_chk_part
    $error("PART_NUMBER must fit 12 bits");
  end
  if (DESIGNER_IDENT < 0 || DESIGNER_IDENT > 127) begin : g_chk_ident
    $error("DESIGNER_IDENT must fit 7 bits");
  end
  if (DESIGNER_BANK < 0 || DESIGNER_BANK > 15) begin : g_chk_bank
    $error("DESIGNER_BANK must fit 4 bits");
  end
  if (REVISION < 0 || REVISION > 15) begin : g_chk_rev
    $error("REVISION must fit 4 bits");
  end
  if (FOUNDRY_REVISION < 0 || FOUNDRY_REVISION > 15) begin : g_chk_frev
    $error("FOUNDRY_REVISION must fit 4 bits");
  end
  if (CUSTOMER_MOD < 0 || CUSTOMER_MOD > 15) begin : g_chk_cmod
    $error("CUSTOMER_MOD must fit 4 bits");
  end

  // field values narrowed to their widths
  localparam logic [11:0] PART_W = 12'(PART_NUMBER);
  localparam logic [3:0] BANK_W = 4'(DESIGNER_BANK);
  localparam logic [6:0] IDENT_W = 7'(DESIGNER_IDENT);
  localparam logic [3:0] REV_W = 4'(REVISION);
  localparam logic [3:0] FREV_W = 4'(FOUNDRY_REVISION);
  localparam logic [3:0] CMOD_W = 4'(CUSTOMER_MOD);
  localparam bit SEC_B = (SEC_EXT == 1);

  // maps a byte address to a register slot
  function automatic logic [3:0] dba_slot(input logic [11:0] a);
    logic [3:0] s;
    s = dba_pkg::SLOT_NONE;
    case (a)
      dba_pkg::PERM_OFS: s = dba_pkg::SLOT_PERM;
      dba_pkg::CLASS_OFS: s = dba_pkg::SLOT_CLASS;
      dba_pkg::ID4_OFS: s = dba_pkg::SLOT_ID4;
      dba_pkg::ID5_OFS: s = dba_pkg::SLOT_RSVD;
      dba_pkg::ID6_OFS: s = dba_pkg::SLOT_RSVD;
      dba_pkg::ID7_OFS: s = dba_pkg::SLOT_RSVD;
      dba_pkg::ID0_OFS: s = dba_pkg::SLOT_ID0;
      dba_pkg::ID1_OFS: s = dba_pkg::SLOT_ID1;
      dba_pkg::ID2_OFS: s = dba_pkg::SLOT_ID2;
      dba_pkg::ID3_OFS: s = dba_pkg::SLOT_ID3;
      default: s = dba_pkg::SLOT_NONE;
    endcase
    return s;
  endfunction : dba_slot

  dba_pkg::dba_bus_req_t req;
  dba_pkg::dba_enables_t en_raw;
  dba_pkg::dba_enables_t en_f;
  logic [3:0] en_f_bits;
  logic [31:0] perm_word;
  logic [7:0] id_byte [0:4];
  logic [31:0] class_word;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  dba_pkg::dba_state_t state_r;
  dba_pkg::dba_state_t state_nxt;

  // gather port signals into carriers
  assign req.addr = bus_addr;
  assign req.wdata = bus_wdata; // never stored
  assign req.wr = bus_wr;
  assign req.rd = bus_rd;
  assign en_raw.inv = invasive_debug_enable_in;
  assign en_raw.noninv = noninvasive_debug_enable_in;
  assign en_raw.sec_inv = secure_invasive_debug_enable_in;
  assign en_raw.sec_noninv = secure_noninvasive_debug_enable_in;
  assign en_f = en_f_bits;

  // enable pins cross into the clock domain
  dba_sync #(
    .W(dba_pkg::EN_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(en_raw),
    .filt_out(en_f_bits)
  );

  // permission word from the filtered enables
  dba_perm #(
    .SEC_EXT(SEC_B)
  ) u_perm (
    .en(en_f),
    .status(perm_word)
  );

  // fixed identification bytes
  assign id_byte[0] = PART_W[7:0];
  assign id_byte[1] = {IDENT_W[3:0], PART_W[11:8]};
  assign id_byte[2] = {REV_W, dba_pkg::ID2_FIXED_ONE,
    IDENT_W[6:4]};
  assign id_byte[3] = {FREV_W, CMOD_W};
  assign id_byte[4] = {dba_pkg::BLOCK_COUNT, BANK_W};
  assign class_word = {24'h00_0000, dba_pkg::CLASS_SUB_TYPE,
    dba_pkg::CLASS_MAIN};

  // read data selected by slot, zero for unmapped
  always_comb begin
    rdata_nxt = dba_pkg::RDATA_RST;
    if (req.rd) begin
      case (dba_slot(req.addr))
        dba_pkg::SLOT_PERM: rdata_nxt = perm_word;
        dba_pkg::SLOT_CLASS: rdata_nxt = class_word;
        dba_pkg::SLOT_ID4: rdata_nxt = {24'h00_0000, id_byte[4]};
        dba_pkg::SLOT_RSVD: rdata_nxt = dba_pkg::RDATA_RST;
        dba_pkg::SLOT_ID0: rdata_nxt = {24'h00_0000, id_byte[0]};
        dba_pkg::SLOT_ID1: rdata_nxt = {24'h00_0000, id_byte[1]};
        dba_pkg::SLOT_ID2: rdata_nxt = {24'h00_0000, id_byte[2]};
        dba_pkg::SLOT_ID3: rdata_nxt = {24'h00_0000, id_byte[3]};
        default: rdata_nxt = dba_pkg::RDATA_RST;
      endcase
    end
  end

  // answer phase follows each read strobe
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dba_pkg::DBA_IDLE: begin
        if (req.rd) begin
          state_nxt = dba_pkg::DBA_ANSWER;
        end
      end
      dba_pkg::DBA_ANSWER: begin
        if (!req.rd) begin
          state_nxt = dba_pkg::DBA_IDLE;
        end
      end
      default: state_nxt = dba_pkg::DBA_IDLE;
    endcase
  end

  // answer state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= dba_pkg::DBA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // read data register, cleared outside the answer cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= dba_pkg::RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt; // write strobe has no path here
    end
  end

  assign bus_rdata = rdata_r;

  // permission bit 0 follows invasive enable with extensions
  perm_bit0_a: assert property (@(posedge clk) disable iff (rst)
    (SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[0] == $past(en_f.inv))
    else $error("permission bit 0 wrong");

  // permission bit 2 is set by the invasive or the noninvasive enable
  perm_bit2_a: assert property (@(posedge clk) disable iff (rst)
    (SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[2] == ($past(en_f.inv) | $past(en_f.noninv)))
    else $error("permission bit 2 wrong");

  // permission bit 4 needs both invasive enables
  perm_bit4_a: assert property (@(posedge clk) disable iff (rst)
    (SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[4] == ($past(en_f.inv) & $past(en_f.sec_inv)))
    else $error("permission bit 4 wrong");

  // permission bit 6 combines both pairs
  perm_bit6_a: assert property (@(posedge clk) disable iff (rst)
    (SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[6] == (($past(en_f.inv) | $past(en_f.noninv)) &
      ($past(en_f.sec_inv) | $past(en_f.sec_noninv))))
    else $error("permission bit 6 wrong");

  // fixed permission bits with extensions
  perm_fixed_a: assert property (@(posedge clk) disable iff (rst)
    (SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[31:8] == 24'h00_0000 &&
      {bus_rdata[7], bus_rdata[5], bus_rdata[3], bus_rdata[1]} ==
      4'hf)
    else $error("fixed permission bits wrong");

  // permission layout without extensions
  perm_nosec_a: assert property (@(posedge clk) disable iff (rst)
    (!SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[7] && bus_rdata[5] &&
      bus_rdata[6] == ($past(en_f.inv) | $past(en_f.noninv)) &&
      bus_rdata[4] == $past(en_f.inv))
    else $error("permission upper nibble wrong");

  // low nibble zero without extensions
  perm_low_a: assert property (@(posedge clk) disable iff (rst)
    (!SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[3:0] == 4'h0)
    else $error("permission low nibble not zero");

  // class code read back
  class_read_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr == dba_pkg::CLASS_OFS) |=>
      bus_rdata == 32'h0000_0015)
    else $error("class code wrong");

  // id words carry data in the low byte only
  id_upper_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr >= dba_pkg::ID4_OFS &&
      bus_addr <= dba_pkg::ID3_OFS) |=>
      bus_rdata[31:8] == 24'h00_0000)
    else $error("id word upper bits not zero");

  // reserved id slots read zero
  id_rsvd_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && dba_slot(bus_addr) == dba_pkg::SLOT_RSVD) |=>
      bus_rdata == 32'h0000_0000)
    else $error("reserved id slot not zero");

  // byte four shows zero count and bank code
  id_four_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr == dba_pkg::ID4_OFS) |=>
      bus_rdata[7:4] == 4'h0 && bus_rdata[3:0] == BANK_W)
    else $error("byte four wrong");

  // part number split over bytes zero and one
  id_part_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr == dba_pkg::ID0_OFS) ##1
      (bus_rd && bus_addr == dba_pkg::ID1_OFS) |=>
      {bus_rdata[3:0], $past(bus_rdata[7:0])} == PART_W &&
      bus_rdata[7:4] == IDENT_W[3:0])
    else $error("part number or identity split wrong");

  // byte two layout
  id_two_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr == dba_pkg::ID2_OFS) |=>
      bus_rdata[7:0] == {REV_W, 1'b1, IDENT_W[6:4]})
    else $error("byte two wrong");

  // byte three layout
  id_three_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr == dba_pkg::ID3_OFS) |=>
      bus_rdata[7:0] == {FREV_W, CMOD_W})
    else $error("byte three wrong");

  // a write alone never produces read data
  write_ignored_a: assert property (@(posedge clk) disable iff (rst)
    (bus_wr && !bus_rd) |=> bus_rdata == 32'h0000_0000 &&
      state_r == dba_pkg::DBA_IDLE)
    else $error("write disturbed read data");

  // read data stand only in the answer cycle
  answer_only_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dba_pkg::DBA_IDLE) |-> bus_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");

  // a read strobe opens the answer phase
  read_answer_a: assert property (@(posedge clk) disable iff (rst)
    bus_rd |=>
      state_r == dba_pkg::DBA_ANSWER)
    else $error("no answer phase after read");

  // answer stands one cycle only
  answer_drop_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd ##1 !bus_rd) |=>
      bus_rdata == 32'h0000_0000)
    else $error("read data outlived its cycle");

  // unmapped and misaligned addresses read zero
  unmapped_zero_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && dba_slot(bus_addr) == dba_pkg::SLOT_NONE) |=>
      bus_rdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  // byte zero holds the low part bits
  id_zero_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr == dba_pkg::ID0_OFS) |=>
      bus_rdata[7:0] == PART_W[7:0])
    else $error("byte zero wrong");

  // byte one: identity low bits over part high bits
  id_one_a: assert property (@(posedge clk) disable iff (rst)
    (bus_rd && bus_addr == dba_pkg::ID1_OFS) |=>
      bus_rdata[7:0] == {IDENT_W[3:0], PART_W[11:8]})
    else $error("byte one wrong");

  // reserved high bits without extensions
  perm_upper_a: assert property (@(posedge clk) disable iff (rst)
    (!SEC_B && bus_rd && bus_addr == dba_pkg::PERM_OFS) |=>
      bus_rdata[31:8] == 24'h00_0000)
    else $error("permission upper bits not zero");
endmodule : dba_regs

// ===== sim/dba_host.sv
// debugger-side model driving the register port of two banks
`timescale 1ns/100ps
module dba_host (
  output logic [11:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic clk,
  input wire logic [31:0] rdata_sec,
  input wire logic [31:0] rdata_plain
);
  // quiet port at time zero
  initial begin
    bus_addr = 12'h000;
    bus_wdata = 32'h0000_0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // strobes drop; released lines show the inverse, not a stale value
  task automatic drop_bus(input logic [11:0] a, input logic [31:0] d);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask : drop_bus

  // one strobe; r[0..1] answer cycle, r[2..3] the cycle after
  task automatic access(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [3:0][31:0] r);
    @(posedge clk);
    bus_wr <= wr;
    bus_rd <= ~wr;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    drop_bus(a, d);
    @(negedge clk);
    r[0] = rdata_sec;
    r[1] = rdata_plain;
    @(negedge clk);
    r[2] = rdata_sec;
    r[3] = rdata_plain;
  endtask : access

  // two reads with no gap; r[0..1] first answer, r[2..3] second
  task automatic read_pair(input logic [11:0] a0, input logic [11:0] a1,
      output logic [3:0][31:0] r);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a0;
    @(posedge clk);
    bus_addr <= a1;
    @(negedge clk);
    r[0] = rdata_sec;
    r[1] = rdata_plain;
    @(posedge clk);
    drop_bus(a1, bus_wdata);
    @(negedge clk);
    r[2] = rdata_sec;
    r[3] = rdata_plain;
  endtask : read_pair
endmodule : dba_host

// ===== sim/debug_auth_and_id_registers_test.sv
// self-checking bench for the debug permission and id register bank
`timescale 1ns/100ps
module debug_auth_and_id_registers_test;
  // bench build values; bank and identity are arbitrary values
  localparam logic [11:0] P_PART = 12'h5a3;
  localparam logic [3:0] P_BANK = 4'h9;
  localparam logic [6:0] P_IDENT = 7'h52;
  localparam logic [3:0] P_REV = 4'h2;
  localparam logic [3:0] P_FREV = 4'h1;
  localparam logic [3:0] P_CMOD = 4'h0;

  logic clk, rst, bus_wr, bus_rd;
  logic [11:0] bus_addr;
  logic [31:0] bus_wdata, rdata_sec, rdata_plain;
  dba_pkg::dba_enables_t en_r;
  logic [3:0][31:0] r;
  int failures, tests_run;
  int cycles = 0;
  logic [11:0] addrs[14] = '{dba_pkg::PERM_OFS, dba_pkg::CLASS_OFS,
    dba_pkg::ID4_OFS, dba_pkg::ID5_OFS, dba_pkg::ID6_OFS, dba_pkg::ID7_OFS,
    dba_pkg::ID0_OFS, dba_pkg::ID1_OFS, dba_pkg::ID2_OFS, dba_pkg::ID3_OFS,
    12'hfb0, 12'hfd1, 12'h000, 12'hff0};

  // bank with security extensions, and one without
  dba_regs #(.SEC_EXT(1), .PART_NUMBER(P_PART), .DESIGNER_BANK(P_BANK),
    .DESIGNER_IDENT(P_IDENT), .REVISION(P_REV), .FOUNDRY_REVISION(P_FREV),
    .CUSTOMER_MOD(P_CMOD)) dba_regs_inst (.clk(clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(rdata_sec),
    .invasive_debug_enable_in(en_r.inv),
    .noninvasive_debug_enable_in(en_r.noninv),
    .secure_invasive_debug_enable_in(en_r.sec_inv),
    .secure_noninvasive_debug_enable_in(en_r.sec_noninv));
  dba_regs #(.SEC_EXT(0), .PART_NUMBER(P_PART), .DESIGNER_BANK(P_BANK),
    .DESIGNER_IDENT(P_IDENT), .REVISION(P_REV), .FOUNDRY_REVISION(P_FREV),
    .CUSTOMER_MOD(P_CMOD)) dba_regs_inst2 (.clk(clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(rdata_plain),
    .invasive_debug_enable_in(en_r.inv),
    .noninvasive_debug_enable_in(en_r.noninv),
    .secure_invasive_debug_enable_in(en_r.sec_inv),
    .secure_noninvasive_debug_enable_in(en_r.sec_noninv));
  dba_host dba_host_inst (.clk(clk), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .rdata_sec(rdata_sec), .rdata_plain(rdata_plain));

  // expected read value of each word
  function automatic logic [31:0] model(input logic [11:0] a,
      input bit sec, input dba_pkg::dba_enables_t e);
    logic i, n, s, t;
    i = e.inv;
    n = e.noninv;
    s = e.sec_inv;
    t = e.sec_noninv;
    case (a)
      dba_pkg::PERM_OFS: model = sec ?
        {24'h0, 1'b1, (i | n) & (s | t), 1'b1, i & s, 1'b1, i | n, 1'b1, i}
        : {24'h0, 1'b1, i | n, 1'b1, i, 4'h0};
      dba_pkg::CLASS_OFS: model = {24'h0, 4'h1, 4'h5};
      dba_pkg::ID4_OFS: model = {24'h0, 4'h0, P_BANK};
      dba_pkg::ID0_OFS: model = {24'h0, P_PART[7:0]};
      dba_pkg::ID1_OFS: model = {24'h0, P_IDENT[3:0], P_PART[11:8]};
      dba_pkg::ID2_OFS: model = {24'h0, P_REV, 1'b1, P_IDENT[6:4]};
      dba_pkg::ID3_OFS: model = {24'h0, P_FREV, P_CMOD};
      default: model = 32'h0;
    endcase
  endfunction : model

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // new enable levels, then time for the synchroniser to settle
  task automatic set_en(input logic [3:0] v);
    @(posedge clk);
    en_r <= dba_pkg::dba_enables_t'(v);
    repeat (5) @(posedge clk);
  endtask : set_en

  // one access to both banks, answers judged against the model
  task automatic judge(input logic wr, input logic [11:0] a);
    logic [31:0] es, ep;
    dba_host_inst.access(wr, a, $urandom, r);
    es = wr ? 32'h0 : model(a, 1'b1, en_r);
    ep = wr ? 32'h0 : model(a, 1'b0, en_r);
    check(r[0], es);
    check(r[1], ep);
    check(r[1], ep);
    check(r[2], 32'h0);
    check(r[3], 32'h0);
  endtask : judge

  // every mapped and reserved address, and four unmapped or misaligned ones
  task automatic sweep(input logic wr);
    foreach (addrs[k]) judge(wr, addrs[k]);
  endtask : sweep

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    rst = 1'b1;
    en_r = '0;
    failures = 0;
    tests_run = 0;
    void'($urandom(32'ha63c));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    set_en(4'h0);
    sweep(1'b0);
    $display("test map sweep done");
    for (int v = 0; v < 16; v++) begin
      set_en(v[3:0]);
      judge(1'b0, dba_pkg::PERM_OFS);
    end
    $display("test enable combinations done");
    set_en(4'ha);
    sweep(1'b1);
    sweep(1'b0);
    $display("test ignored writes done");
    for (int k = 0; k < 30; k++) begin
      set_en(4'($urandom));
      judge(1'($urandom), addrs[$urandom % 14]);
    end
    $display("test random traffic done");
    dba_host_inst.read_pair(dba_pkg::CLASS_OFS, dba_pkg::ID0_OFS, r);
    check(r[0], model(dba_pkg::CLASS_OFS, 1'b1, en_r));
    check(r[3], model(dba_pkg::ID0_OFS, 1'b0, en_r));
    dba_host_inst.read_pair(dba_pkg::PERM_OFS, dba_pkg::ID4_OFS, r);
    check(r[0], model(dba_pkg::PERM_OFS, 1'b1, en_r));
    check(r[1], model(dba_pkg::PERM_OFS, 1'b0, en_r));
    check(r[2], model(dba_pkg::ID4_OFS, 1'b1, en_r));
    dba_host_inst.read_pair(dba_pkg::ID0_OFS, dba_pkg::ID1_OFS, r);
    check(r[1], model(dba_pkg::ID0_OFS, 1'b0, en_r));
    check(r[2], model(dba_pkg::ID1_OFS, 1'b1, en_r));
    $display("test back to back reads done");
    set_en(4'hf);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) begin
      @(negedge clk);
      check(rdata_sec, 32'h0);
      check(rdata_plain, 32'h0);
    end
    @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    sweep(1'b0);
    $display("test mid-run reset done");
    conclude();
  end
endmodule : debug_auth_and_id_registers_test
